// ---- hdl/memctl.v ----
// Memory controller front end: area decode, remap, abort and flash mode.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`include "memctl_consts.vh"

module memctl #(
    parameter WAIT_W = 2,
    parameter FMCN_W = 8
) (
    // Clock and synchronous reset.
    input wire CLOCK,
    input wire SRST,
    // Wishbone register slave.
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    // Bus master access request.
    input wire MST_REQ,
    input wire [31:0] MST_ADDR,
    input wire [1:0] MST_SIZE,
    input wire MST_WRITE,
    input wire [1:0] MST_ID,
    // Decoded access towards the memories.
    output reg MEM_VALID,
    output reg [2:0] MEM_SEL,
    output reg [19:0] MEM_OFFSET,
    output reg MEM_WRITE,
    output reg [1:0] MEM_SIZE,
    output reg ABORT,
    output reg REMAPPED,
    // Flash controller events and settings, two banks.
    input wire [1:0] FLASH_READY_EV,
    input wire [1:0] LOCK_ERR_EV,
    input wire [1:0] PROG_ERR_EV,
    output reg [1:0] ERASE_BEFORE_PROG,
    output reg [5:0] FLASH_RD_CYCLES,
    output reg [5:0] FLASH_WR_CYCLES,
    output wire FLASH_IRQ,
    // Summary interrupt.
    output wire IRQ
);

    reg ack_reg;
    reg remap_reg;
    reg remap_next;
    reg [31:0] abort_addr_reg;
    reg [31:0] abort_status_reg;
    reg [`IRQ_WIDTH-1:0] irq_status_reg;
    reg [`IRQ_WIDTH-1:0] irq_status_next;
    reg [`IRQ_WIDTH-1:0] irq_mask_reg;
    reg [31:0] flash_mode_reg0;
    reg [31:0] flash_mode_reg1;
    reg [31:0] rd_data;
    reg [31:0] wmask;
    reg [`IRQ_WIDTH-1:0] irq_clear;
    reg [`IRQ_WIDTH-1:0] irq_set;
    reg undef_hit;
    reg misalign_hit;
    reg [2:0] sel_next;
    wire wr_take;
    wire [1:0] area;
    wire [3:0] ev0;
    wire [3:0] ev1;

    // Read cycles are one plus the wait field.
    function [2:0] rd_cycles;
        input [WAIT_W-1:0] ws;
        begin
            rd_cycles = 3'h1 + {1'b0, ws};
        end
    endfunction

    // Write cycles saturate at four: 2, 3, 4, 4.
    function [2:0] wr_cycles;
        input [WAIT_W-1:0] ws;
        begin
            case (ws)
                2'h0: wr_cycles = 3'h2;
                2'h1: wr_cycles = 3'h3;
                default: wr_cycles = 3'h4;
            endcase
        end
    endfunction

    // Misalignment depends only on size and the low address bits.
    function misaligned;
        input [1:0] size;
        input [1:0] a;
        begin
            case (size)
                `SIZE_BYTE: misaligned = 1'b0;
                `SIZE_HALF: misaligned = a[0];
                default: misaligned = (a != 2'h0);
            endcase
        end
    endfunction

    // A write is taken at the edge that raises the acknowledge.
    assign wr_take = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_reg;
    assign area = MST_ADDR[21:20];

    // Byte lane mask built from the selects.
    always @* begin
        wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                 {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    end

    // Remap toggles on each write of one to the remap bit.
    always @* begin
        remap_next = remap_reg;
        if (wr_take && WB_ADR_I == `OFS_REMAP_CTRL && WB_SEL_I[0] &&
            WB_DAT_I[`REMAP_BIT]) begin
            remap_next = ~remap_reg; // R6 R7
        end
    end

    // Abort causes: above area 3, or misaligned for the size.
    always @* begin
        undef_hit = (MST_ADDR[31:22] != 10'h000); // R8
        misalign_hit = misaligned(MST_SIZE, MST_ADDR[1:0]); // R8
    end

    // Area decode; area 0 follows the remap state so that the vector
    // table at address zero, reset vector included, comes from the
    // aliased memory, which also stays visible at its own base.
    always @* begin
        case (area)
            `AREA_ZERO: sel_next = remap_reg ? `SEL_SRAM : `SEL_FLASH; // R1 R3 R4 R5
            `AREA_FLASH: sel_next = `SEL_FLASH; // R2
            `AREA_SRAM: sel_next = `SEL_SRAM; // R2
            `AREA_ROM: sel_next = `SEL_ROM; // R2
            default: sel_next = `SEL_NONE;
        endcase
    end

    // Flash events of each bank laid out as in the flash mode register.
    assign ev0 = {PROG_ERR_EV[0], LOCK_ERR_EV[0], 1'b0, FLASH_READY_EV[0]};
    assign ev1 = {PROG_ERR_EV[1], LOCK_ERR_EV[1], 1'b0, FLASH_READY_EV[1]};

    // Sticky status: a new event wins over a clear in the same cycle.
    always @* begin
        irq_set = {MST_REQ & (undef_hit | misalign_hit), ev1, ev0};
        irq_clear = {`IRQ_WIDTH{1'b0}};
        if (wr_take && WB_ADR_I == `OFS_IRQ_STATUS) begin
            irq_clear = WB_DAT_I[`IRQ_WIDTH-1:0] & wmask[`IRQ_WIDTH-1:0];
        end
        irq_status_next = (irq_status_reg & ~irq_clear) | irq_set;
    end

    // Read multiplexer; unmapped offsets read as zero.
    always @* begin
        case (WB_ADR_I)
            `OFS_REMAP_CTRL: rd_data = {31'h00000000, remap_reg};
            `OFS_ABORT_STATUS: rd_data = abort_status_reg;
            `OFS_ABORT_ADDR: rd_data = abort_addr_reg;
            `OFS_IRQ_STATUS: rd_data = {23'h000000, irq_status_reg};
            `OFS_IRQ_MASK: rd_data = {23'h000000, irq_mask_reg};
            `OFS_FLASH_MODE0: rd_data = flash_mode_reg0;
            `OFS_FLASH_MODE1: rd_data = flash_mode_reg1;
            default: rd_data = 32'h00000000;
        endcase
    end

    // Wishbone slave: one wait-free answer per request, then ack drops.
    always @(posedge CLOCK) begin
        if (SRST) begin
            ack_reg <= 1'b0;
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            ack_reg <= WB_CYC_I & WB_STB_I & ~ack_reg;
            WB_ACK_O <= WB_CYC_I & WB_STB_I & ~ack_reg;
            if (WB_CYC_I & WB_STB_I & ~ack_reg) begin
                WB_DAT_O <= rd_data;
            end
        end
    end

    // Software registers: remap, mask, status and flash modes.
    always @(posedge CLOCK) begin
        if (SRST) begin
            remap_reg <= 1'b0; // R3
            irq_mask_reg <= {`IRQ_WIDTH{1'b0}};
            irq_status_reg <= {`IRQ_WIDTH{1'b0}};
            flash_mode_reg0 <= `FM_RESET;
            flash_mode_reg1 <= `FM_RESET;
        end else begin
            remap_reg <= remap_next;
            irq_status_reg <= irq_status_next;
            if (wr_take && WB_ADR_I == `OFS_IRQ_MASK) begin
                irq_mask_reg <= (irq_mask_reg & ~wmask[`IRQ_WIDTH-1:0]) |
                    (WB_DAT_I[`IRQ_WIDTH-1:0] & wmask[`IRQ_WIDTH-1:0]);
            end
            if (wr_take && WB_ADR_I == `OFS_FLASH_MODE0) begin
                flash_mode_reg0 <= (flash_mode_reg0 & ~wmask) |
                    (WB_DAT_I & wmask & `FM_WRITABLE); // R13
            end
            if (wr_take && WB_ADR_I == `OFS_FLASH_MODE1) begin
                flash_mode_reg1 <= (flash_mode_reg1 & ~wmask) |
                    (WB_DAT_I & wmask & `FM_WRITABLE); // R13
            end
        end
    end

    // Abort capture keeps the latest faulting access for diagnosis.
    always @(posedge CLOCK) begin
        if (SRST) begin
            abort_addr_reg <= 32'h00000000;
            abort_status_reg <= 32'h00000000;
        end else if (MST_REQ && (undef_hit || misalign_hit)) begin
            abort_addr_reg <= MST_ADDR; // R11
            abort_status_reg <= 32'h00000000;
            abort_status_reg[`AS_SIZE_MSB:`AS_SIZE_LSB] <= MST_SIZE; // R12
            abort_status_reg[`AS_WRITE] <= MST_WRITE; // R12
            abort_status_reg[`AS_MASTER_MSB:`AS_MASTER_LSB] <= MST_ID; // R12
            abort_status_reg[`AS_UNDEF] <= undef_hit; // R12
            abort_status_reg[`AS_MISALIGN] <= misalign_hit; // R12
        end
    end

    // Access path: the abort is one shared line, so every master sees
    // it; masters other than the processor simply ignore it.
    always @(posedge CLOCK) begin
        if (SRST) begin
            MEM_VALID <= 1'b0;
            MEM_SEL <= `SEL_NONE;
            MEM_OFFSET <= 20'h00000;
            MEM_WRITE <= 1'b0;
            MEM_SIZE <= `SIZE_BYTE;
            ABORT <= 1'b0;
        end else begin
            ABORT <= MST_REQ & (undef_hit | misalign_hit); // R9 R10
            MEM_VALID <= MST_REQ & ~undef_hit & ~misalign_hit; // R8
            MEM_SEL <= (MST_REQ & ~undef_hit & ~misalign_hit) ?
                sel_next : `SEL_NONE;
            MEM_OFFSET <= MST_ADDR[19:0]; // R5
            MEM_WRITE <= MST_WRITE;
            MEM_SIZE <= MST_SIZE;
        end
    end

    // Flash settings are driven from registers to keep outputs clean.
    always @(posedge CLOCK) begin
        if (SRST) begin
            REMAPPED <= 1'b0;
            ERASE_BEFORE_PROG <= `ERASE_RESET;
            FLASH_RD_CYCLES <= `RD_CYCLES_RESET;
            FLASH_WR_CYCLES <= `WR_CYCLES_RESET;
        end else begin
            REMAPPED <= remap_reg;
            ERASE_BEFORE_PROG <= {~flash_mode_reg1[`FM_SKIP_ERASE],
                ~flash_mode_reg0[`FM_SKIP_ERASE]}; // R14
            FLASH_RD_CYCLES <= {
                rd_cycles(flash_mode_reg1[`FM_WAIT_MSB:`FM_WAIT_LSB]),
                rd_cycles(flash_mode_reg0[`FM_WAIT_MSB:`FM_WAIT_LSB])}; // R15
            FLASH_WR_CYCLES <= {
                wr_cycles(flash_mode_reg1[`FM_WAIT_MSB:`FM_WAIT_LSB]),
                wr_cycles(flash_mode_reg0[`FM_WAIT_MSB:`FM_WAIT_LSB])}; // R15
        end
    end

    // Flash interrupt ignores the general mask; only the mode enables
    // gate it, so flash handlers work without touching the mask.
    assign FLASH_IRQ =
        |(irq_status_reg[3:0] & flash_mode_reg0[3:0] & `FM_EVENT_MASK) |
        |(irq_status_reg[7:4] & flash_mode_reg1[3:0] & `FM_EVENT_MASK); // R13 R16

    // Summary interrupt: any unmasked sticky status bit.
    assign IRQ = |(irq_status_reg & irq_mask_reg);

endmodule // memctl

// ---- hdl/memctl_consts.vh ----
// Constants for the memory controller front end: offsets, fields, codes.
// Functional notes
// R1: Exception vectors occupy lowest 32 bytes of area 0; reset vector at zero.
// R2: Area 1 decodes flash, area 2 SRAM, area 3 ROM, one megabyte each.
// R3: From reset until remap, flash is aliased into area 0 for boot.
// R4: After remap, SRAM is aliased into area 0 instead of flash.
// R5: Aliased memory answers at both its own base and address zero.
// R6: Writing one to the remap bit switches the area 0 alias to SRAM.
// R7: Each such write toggles the mapping; a second restores the flash alias.
// R8: Abort on accesses above area 3 and on misaligned addresses.
// R9: The abort indication goes to every bus master at once.
// R10: Only the processor acts on abort, and only for its own access.
// R11: The full 32-bit address of an aborted access is captured.
// R12: Aborted access attributes, including size, are recorded in abort status.
// R13: Flash mode holds ready, lock-error, program-error interrupt enables at 0,2,3.
// R14: Skip-erase bit 7 clear erases page before program; set skips erase.
// R15: Wait field gives read cycles 1+value; write cycles 2,3,4,4.
// R16: Flash interrupt is high while an enabled flash event is pending.
`ifndef MEMCTL_CONSTS_VH
`define MEMCTL_CONSTS_VH

// Register byte offsets.
`define OFS_REMAP_CTRL 8'h00
`define OFS_ABORT_STATUS 8'h04
`define OFS_ABORT_ADDR 8'h08
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_FLASH_MODE0 8'h60
`define OFS_FLASH_MODE1 8'h70

// Remap control field.
`define REMAP_BIT 0

// Flash mode fields.
`define FM_READY_EN 0
`define FM_LOCK_EN 2
`define FM_PROG_EN 3
`define FM_SKIP_ERASE 7
`define FM_WAIT_LSB 8
`define FM_WAIT_MSB 9
`define FM_WRITABLE 32'h00FF038D
`define FM_RESET 32'h00000000
`define FM_EVENT_MASK 4'hD

// Reset values of the registered flash setting outputs.
`define ERASE_RESET 2'h3
`define RD_CYCLES_RESET 6'h09
`define WR_CYCLES_RESET 6'h12

// Interrupt status layout: bank 0 events, bank 1 events, abort.
`define IRQ_BANK1_LSB 4
`define IRQ_ABORT 8
`define IRQ_WIDTH 9

// Abort status fields.
`define AS_SIZE_LSB 0
`define AS_SIZE_MSB 1
`define AS_WRITE 2
`define AS_MASTER_LSB 4
`define AS_MASTER_MSB 5
`define AS_UNDEF 8
`define AS_MISALIGN 9

// Access sizes.
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// Internal memory areas and selects.
`define AREA_ZERO 2'h0
`define AREA_FLASH 2'h1
`define AREA_SRAM 2'h2
`define AREA_ROM 2'h3
`define SEL_NONE 3'h0
`define SEL_FLASH 3'h1
`define SEL_SRAM 3'h2
`define SEL_ROM 3'h4
`define VECTOR_BYTES 32

`endif

// ---- verification/bus_master_model.sv ----
// Behavioural on-chip bus master issuing single accesses.
`timescale 1ns/100ps
module bus_master_model (
    // Clock.
    input wire clock,
    // Request towards the controller.
    output reg req,
    output reg [31:0] addr,
    output reg [1:0] size,
    output reg write,
    output reg [1:0] id,
    // Abort seen by every master, and the one the processor acts on.
    input wire abort,
    output wire cpu_abort
);
    reg own_q = 1'b0;
    initial begin
        req = 1'b0;
        addr = 32'h0;
        size = 2'h0;
        write = 1'b0;
        id = 2'h0;
    end
    // DMA masters (id not 0) ignore the abort line entirely.
    always @(posedge clock) begin
        own_q <= req && id == 2'h0;
    end
    assign cpu_abort = abort && own_q;
    // Released address shows the inverse so a stale value never matches.
    task access(input [31:0] a, input [1:0] s, input w, input [1:0] i);
        begin
            @(posedge clock);
            req <= 1'b1;
            addr <= a;
            size <= s;
            write <= w;
            id <= i;
            @(posedge clock);
            req <= 1'b0;
            addr <= ~a;
            #1;
        end
    endtask
endmodule // bus_master_model

// ---- verification/memctl_props.sv ----
// Port-level assertions for the memory controller front end.
`timescale 1ns/100ps
module memctl_props (
    // Clock, reset and register bus.
    input wire CLOCK,
    input wire SRST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    input wire WB_ACK_O,
    // Access port.
    input wire MST_REQ,
    input wire [31:0] MST_ADDR,
    input wire [1:0] MST_SIZE,
    input wire MEM_VALID,
    input wire [2:0] MEM_SEL,
    input wire [19:0] MEM_OFFSET,
    input wire ABORT,
    input wire REMAPPED
);
    // Offset on the address bus in the previous cycle, with or without a request, compared with the decoded access.
    reg [19:0] ofs_q;
    wire new_wb = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire byte_ok = MST_REQ && MST_SIZE == 2'h0 && MST_ADDR[31:22] == 0;
    wire [1:0] area = MST_ADDR[21:20];
    always @(posedge CLOCK) begin
        ofs_q <= MST_ADDR[19:0];
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    ack_pulse_a: assert property (new_wb |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack is not a one-cycle answer");
    undef_abort_a: assert property (
        MST_REQ && MST_ADDR[31:22] != 0 |=> ABORT && !MEM_VALID)
        else $error("undefined area not aborted");
    misalign_abort_a: assert property (
        MST_REQ && (MST_SIZE == 2'h1 && MST_ADDR[0] ||
        MST_SIZE[1] && MST_ADDR[1:0] != 0) |=> ABORT && !MEM_VALID)
        else $error("misaligned access not aborted");
    area_zero_a: assert property (
        byte_ok && area == 0 |=> MEM_VALID &&
        MEM_SEL == (REMAPPED ? 3'h2 : 3'h1))
        else $error("area zero alias wrong");
    flash_area_a: assert property (
        byte_ok && area == 1 |=> MEM_VALID && MEM_SEL == 3'h1)
        else $error("flash area decode wrong");
    sram_area_a: assert property (
        byte_ok && area == 2 |=> MEM_VALID && MEM_SEL == 3'h2)
        else $error("sram area decode wrong");
    rom_area_a: assert property (
        byte_ok && area == 3 |=> MEM_VALID && MEM_SEL == 3'h4)
        else $error("rom area decode wrong");
    offset_copy_a: assert property (MEM_VALID |-> MEM_OFFSET == ofs_q)
        else $error("offset not passed on");
    remap_toggle_a: assert property (
        new_wb && WB_WE_I && WB_ADR_I == 8'h00 && WB_SEL_I[0] &&
        WB_DAT_I[0] |=> ##1 REMAPPED != $past(REMAPPED))
        else $error("remap bit did not toggle");
    abort_cause_a: assert property (
        ABORT |-> $past(MST_REQ) && !MEM_VALID)
        else $error("abort without a request");
endmodule // memctl_props

// ---- verification/tb.sv ----
// Self-checking bench for the memory controller front end.
`timescale 1ns/100ps
module tb;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg cyc = 1'b0;
    reg we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [31:0] wdat = 32'h0;
    reg [1:0] rdy = 2'h0;
    reg [1:0] lck = 2'h0;
    reg [1:0] prg = 2'h0;
    reg [3:0] sel = 4'hF;
    reg [3:0] lanes = 4'hF;
    wire [31:0] rdat, maddr;
    wire ack, req, mw, abort, remap, valid, firq, irq, cpu_abort, mwr;
    wire [1:0] msize, mid, ebp, msz;
    wire [2:0] msel;
    wire [19:0] mofs;
    wire [5:0] rdc, wrc;
    integer bad_count = 0;
    integer checks_done = 0;
    integer k;
    reg [31:0] v;
    always #5 clk = ~clk;
    memctl dut (.CLOCK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .MST_REQ(req), .MST_ADDR(maddr),
        .MST_SIZE(msize), .MST_WRITE(mw), .MST_ID(mid), .MEM_VALID(valid),
        .MEM_SEL(msel), .MEM_OFFSET(mofs), .MEM_WRITE(mwr), .MEM_SIZE(msz),
        .ABORT(abort), .REMAPPED(remap), .FLASH_READY_EV(rdy),
        .LOCK_ERR_EV(lck), .PROG_ERR_EV(prg), .ERASE_BEFORE_PROG(ebp),
        .FLASH_RD_CYCLES(rdc), .FLASH_WR_CYCLES(wrc), .FLASH_IRQ(firq),
        .IRQ(irq));
    bus_master_model mm (.clock(clk), .req(req), .addr(maddr),
        .size(msize), .write(mw), .id(mid), .abort(abort),
        .cpu_abort(cpu_abort));
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks_done, bad_count);
            if (bad_count == 0 && checks_done > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("unexpected %0s: expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // Classic cycle; strobe is tied to cyc, so both move together.
    task wb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            cyc <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            sel <= lanes;
            n = 0;
            @(posedge clk);
            while (ack !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge clk);
            end
            if (n == 20) begin
                bad_count = bad_count + 1;
                test_done;
            end
            v = rdat;
            cyc <= 1'b0;
            we <= 1'b0;
            #1;
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            wb(1'b0, a, 32'h0);
            chk("register", e, v);
        end
    endtask
    task abt(input [31:0] a, input [1:0] s, input w, input [1:0] i,
        input [31:0] st);
        begin
            mm.access(a, s, w, i);
            chk("abort", 1, abort);
            chk("cpu_abort", i == 2'h0, cpu_abort);
            rd(8'h08, a);
            rd(8'h04, st);
        end
    endtask
    task ev(input [1:0] r, input [1:0] l, input [1:0] p);
        begin
            @(posedge clk);
            rdy <= r;
            lck <= l;
            prg <= p;
            @(posedge clk);
            rdy <= 2'h0;
            lck <= 2'h0;
            prg <= 2'h0;
            #1;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("erase", 3, ebp);
        chk("rd_cycles", 6'h09, rdc);
        chk("wr_cycles", 6'h12, wrc);
        // Reset vector fetch flips between flash and SRAM per toggle.
        for (k = 0; k < 3; k = k + 1) begin
            mm.access(32'h0, 2'h0, 1'b0, 2'h0);
            chk("area0_sel", k == 1 ? 2 : 1, msel);
            rd(8'h00, k == 1);
            wb(1'b1, 8'h00, 32'h1);
        end
        // Without lane 0 the remap write must leave the mapping alone.
        lanes = 4'hE;
        wb(1'b1, 8'h00, 32'h1);
        lanes = 4'hF;
        rd(8'h00, 1);
        for (k = 1; k < 4; k = k + 1) begin
            mm.access(k << 20, 2'h2, 1'b1, 2'h1);
            chk("area_sel", 1 << (k - 1), msel);
            chk("offset", 0, mofs);
            chk("mem_write", 1, mwr);
            chk("mem_size", 2, msz);
        end
        abt(32'h0040_0000, 2'h2, 1'b0, 2'h1, 32'h112);
        abt(32'h0020_0001, 2'h1, 1'b1, 2'h0, 32'h205);
        abt(32'h0010_0002, 2'h2, 1'b0, 2'h2, 32'h222);
        abt(32'h8000_0000, 2'h0, 1'b0, 2'h3, 32'h130);
        chk("irq_masked", 0, irq);
        rd(8'h10, 32'h100);
        wb(1'b1, 8'h14, 32'h100);
        chk("irq", 1, irq);
        wb(1'b1, 8'h10, 32'h100);
        chk("irq_clear", 0, irq);
        rd(8'h40, 0);
        for (k = 0; k < 4; k = k + 1) begin
            wb(1'b1, 8'h70, k << 8);
            chk("rd_cycles1", k + 1, rdc[5:3]);
            chk("wr_cycles1", k == 3 ? 4 : k + 2, wrc[5:3]);
        end
        wb(1'b1, 8'h60, 32'hFFFF_FFFF);
        rd(8'h60, 32'h00FF_038D);
        chk("erase", 2, ebp);
        // Each enabled bank 0 event raises the flash line until cleared.
        for (k = 0; k < 3; k = k + 1) begin
            ev(k == 0, k == 1, k == 2);
            chk("flash_irq", 1, firq);
            chk("irq_masked", 0, irq);
            wb(1'b1, 8'h10, k == 0 ? 1 : 1 << (k + 1));
            chk("flash_irq", 0, firq);
        end
        ev(2'h2, 2'h2, 2'h2);
        chk("flash_irq_off", 0, firq);
        rd(8'h10, 32'hD0);
        test_done;
    end
endmodule // tb
bind memctl memctl_props props_i (.CLOCK(CLOCK), .SRST(SRST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_ACK_O(WB_ACK_O), .MST_REQ(MST_REQ), .MST_ADDR(MST_ADDR),
    .MST_SIZE(MST_SIZE), .MEM_VALID(MEM_VALID), .MEM_SEL(MEM_SEL),
    .MEM_OFFSET(MEM_OFFSET), .ABORT(ABORT), .REMAPPED(REMAPPED));
